// ==== rtl/cmp_pkg.sv ====
// shared constants and types for the comparator interrupt aggregator.
// assumes a 100 MHz core clock; the other files use it as cmp_pkg::name.
package cmp_pkg;

	// channel count
	localparam int NCH = 16;

	// clock and debounce timing
	localparam real CLK_MHZ = 100.0;
	localparam real DEB_STEP_US = 6.4;
	localparam real DEB_MIN_US = 12.8;
	localparam real DEB_MAX_S = 0.41943045;
	localparam int STEP_CYCLES = $rtoi(DEB_STEP_US * CLK_MHZ);
	localparam logic [15:0] DEB_MIN_STEPS =
		16'($rtoi(DEB_MIN_US / DEB_STEP_US));
	// longest time needs one count past 16 bits, so saturate the setting
	localparam int DEB_MAX_RAW = $rtoi(DEB_MAX_S * 1.0e6 / DEB_STEP_US);
	localparam logic [15:0] DEB_MAX_STEPS =
		(DEB_MAX_RAW > 32'h0000ffff) ? 16'hffff : 16'(DEB_MAX_RAW);

	// register offsets inside the 64-byte logical-address space
	localparam logic [5:0] OFF_RAW = 6'h20;
	localparam logic [5:0] OFF_MASKED = 6'h28;
	localparam logic [5:0] OFF_FIRST = 6'h30;

	// a16 decode: top two bits set, logical address in bits 13:6
	localparam logic [1:0] A16_TOP = 2'h3;
	localparam int LA_LSB = 6;

	// reset values
	localparam logic [7:0] LA_RST = 8'hff;
	localparam logic [15:0] INV_RST = 16'h0000;
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [15:0] DEB_RST = DEB_MIN_STEPS;

	// word-serial query selector
	typedef enum logic [1:0] {
		WS_RAW = 2'b00,
		WS_MASKED = 2'b01,
		WS_FIRST = 2'b10,
		WS_NONE = 2'b11
	} ws_sel_e;

	// host configuration write selector
	typedef enum logic [1:0] {
		CFG_INVERT = 2'b00,
		CFG_ENABLE = 2'b01,
		CFG_DEBOUNCE = 2'b10,
		CFG_SPARE = 2'b11
	} cfg_sel_e;

	// configuration set: per-channel invert and enable bits, one debounce limit shared by all channels
	typedef struct packed {
		logic [15:0] inv;
		logic [15:0] en;
		logic [15:0] deb;
	} cfg_s;

	// one read answer
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} rsp_s;

endpackage

// ==== rtl/cmp_debounce.sv ====
// one channel of digital debounce with a step prescaler.
// assumes din is synchronous to core_clk and lim is at least two steps.
module cmp_debounce #(
	parameter int STEP_CYCLES = cmp_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// level in, step limit, level out
	input wire logic din,
	input wire logic [15:0] lim,
	output logic dout
);

	localparam int SUB_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(STEP_CYCLES - 1);

	logic out_q, out_d;
	logic [SUB_W-1:0] sub_q, sub_d;
	logic [15:0] step_q, step_d;
	logic last;

	always_comb begin
		out_d = out_q;
		sub_d = '0;
		step_d = '0;
		last = 1'b0;
		if (din != out_q) begin
			last = (sub_q == SUB_LAST) && (step_q == lim - 16'h0001);
			sub_d = (sub_q == SUB_LAST) ? '0 : sub_q + SUB_W'(1);
			step_d = (sub_q == SUB_LAST) ? step_q + 16'h0001 : step_q;
			if (last) begin
				out_d = din;
				sub_d = '0;
				step_d = '0;
			end
		end
	end

	// state registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out_q <= 1'b0;
			sub_q <= '0;
			step_q <= '0;
		end else begin
			out_q <= out_d;
			sub_q <= sub_d;
			step_q <= step_d;
		end
	end

	assign dout = out_q;

	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_DEB_ONLY_AT_END: assert property (
		$changed(out_q) |-> $past(din) == out_q &&
			$past(step_q) == $past(lim) - 16'h0001
	) else $error("debounce output changed before the full time");

	AST_DEB_RESTART: assert property (
		(din == out_q) |=> (sub_q == '0 && step_q == 16'h0000)
	) else $error("debounce count not restarted on return");

	COV_DEB_CHANGE: cover property ($changed(out_q));

endmodule

// ==== rtl/cmp_first_latch.sv ====
// first-trip record: keeps the channels that tripped first until cleared.
// assumes clr is a one-cycle pulse from a read of the record.
module cmp_first_latch #(
	parameter int NCH = cmp_pkg::NCH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// masked levels and read-clear
	input wire logic [NCH-1:0] masked,
	input wire logic clr,
	output logic [NCH-1:0] rec
);

	logic [NCH-1:0] prev_q, prev_d;
	logic [NCH-1:0] rec_q, rec_d;
	logic [NCH-1:0] evt;

	always_comb begin
		prev_d = masked;
		evt = masked & ~prev_q;
		rec_d = rec_q;
		if (clr) begin
			rec_d = evt; // a trip in the clearing cycle is kept
		end else if (rec_q == '0) begin
			rec_d = evt;
		end
	end

	// state registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prev_q <= '0;
			rec_q <= '0;
		end else begin
			prev_q <= prev_d;
			rec_q <= rec_d;
		end
	end

	assign rec = rec_q;

	default clocking fcb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_FIRST_HOLD: assert property (
		(rec_q != '0 && !clr) |=> $stable(rec_q)
	) else $error("first record overwritten while armed");

	AST_FIRST_CLEAR: assert property (
		clr |=> rec_q == $past(masked & ~prev_q)
	) else $error("first record not cleared by read");

endmodule

// ==== rtl/cmp_aggregator.sv ====
// top of the comparator interrupt aggregator: debounce, invert, mask,
// or into one interrupt, first-trip record, register and query reads.
// assumes all inputs synchronous to CORE_CLK; the analog comparators and
// the word-serial command parser sit outside and drive the plain ports.

module comparator_interrupt_aggregator #(
	parameter int NCH = cmp_pkg::NCH,
	parameter int STEP_CYCLES = cmp_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// comparator trip levels
	input wire logic [NCH-1:0] CMP_LEVEL,
	// logical address
	input wire logic [7:0] STATIC_LA,
	input wire logic LA_SET,
	input wire logic [7:0] LA_NEW,
	output logic [7:0] LA_CURRENT,
	// a16 register reads
	input wire logic REG_RD,
	input wire logic [15:0] REG_ADDR,
	output logic REG_ACK,
	output logic [15:0] REG_RDATA,
	// word-serial queries
	input wire logic WS_QUERY,
	input wire cmp_pkg::ws_sel_e WS_SEL,
	output logic WS_VALID,
	output logic [15:0] WS_RDATA,
	// host configuration commands
	input wire logic CFG_WR,
	input wire cmp_pkg::cfg_sel_e CFG_SEL,
	input wire logic [15:0] CFG_DATA,
	// interrupt outputs
	output logic INT_LEVEL,
	output logic TRIG_PULSE,
	output logic FP_IRQ_O,
	output logic FP_IRQ_OE_B,
	output logic FP_LATCH_O,
	output logic FP_LATCH_OE_B
);

	cmp_pkg::cfg_s cfg_q, cfg_d;
	logic [7:0] la_q, la_d;
	logic la_armed_q, la_armed_d;
	cmp_pkg::rsp_s reg_q, reg_d;
	cmp_pkg::rsp_s ws_q, ws_d;
	logic irq_q, irq_d;
	logic trig_q, trig_d;
	logic [NCH-1:0] deb_state;
	logic [NCH-1:0] masked;
	logic [NCH-1:0] first_rec;
	logic reg_hit;
	logic first_clr;

	// widen a channel vector to the 16-bit data path
	function automatic logic [15:0] to_word(input logic [NCH-1:0] v);
		logic [15:0] w;
		w = '0;
		w[NCH-1:0] = v;
		return w;
	endfunction

	// clamp a debounce setting into the legal step range
	function automatic logic [15:0] clamp_steps(input logic [15:0] s);
		logic [15:0] r;
		r = s;
		if (s < cmp_pkg::DEB_MIN_STEPS) begin
			r = cmp_pkg::DEB_MIN_STEPS;
		end else if (s > cmp_pkg::DEB_MAX_STEPS) begin
			r = cmp_pkg::DEB_MAX_STEPS;
		end
		return r;
	endfunction

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		cmp_debounce #(
			.STEP_CYCLES(STEP_CYCLES)
		) u_deb (
			.core_clk(CORE_CLK),
			.rst_b(RST_B),
			.din(CMP_LEVEL[i]),
			.lim(cfg_q.deb),
			.dout(deb_state[i])
		);
	end

	assign masked = (deb_state ^ cfg_q.inv[NCH-1:0]) & cfg_q.en[NCH-1:0];

	cmp_first_latch #(
		.NCH(NCH)
	) u_first (
		.core_clk(CORE_CLK),
		.rst_b(RST_B),
		.masked(masked),
		.clr(first_clr),
		.rec(first_rec)
	);

	// host configuration writes
	always_comb begin
		cfg_d = cfg_q;
		if (CFG_WR) begin
			case (CFG_SEL)
				cmp_pkg::CFG_INVERT: cfg_d.inv = CFG_DATA;
				cmp_pkg::CFG_ENABLE: cfg_d.en = CFG_DATA;
				cmp_pkg::CFG_DEBOUNCE: cfg_d.deb = clamp_steps(CFG_DATA);
				default: cfg_d = cfg_q;
			endcase
		end
	end

	// static strap after reset, dynamic set after
	always_comb begin
		la_d = la_q;
		la_armed_d = 1'b1;
		if (LA_SET) begin
			la_d = LA_NEW;
		end else if (!la_armed_q) begin
			la_d = STATIC_LA;
		end
	end

	// address decode in the logical-address space
	assign reg_hit = REG_RD && (REG_ADDR[15:14] == cmp_pkg::A16_TOP) &&
		(REG_ADDR[13:cmp_pkg::LA_LSB] == la_q);

	// either read path clears the first record
	assign first_clr = (reg_hit &&
		REG_ADDR[5:0] == cmp_pkg::OFF_FIRST) ||
		(WS_QUERY && WS_SEL == cmp_pkg::WS_FIRST);

	// register read answers
	always_comb begin
		reg_d.valid = reg_hit;
		reg_d.data = reg_q.data;
		if (reg_hit) begin
			if (REG_ADDR[5:0] == cmp_pkg::OFF_RAW) begin
				reg_d.data = to_word(deb_state);
			end else if (REG_ADDR[5:0] == cmp_pkg::OFF_MASKED) begin
				reg_d.data = to_word(masked);
			end else if (REG_ADDR[5:0] == cmp_pkg::OFF_FIRST) begin
				reg_d.data = to_word(first_rec);
			end else begin
				reg_d.data = 16'h0000;
			end
		end
	end

	always_comb begin
		ws_d.valid = WS_QUERY;
		ws_d.data = ws_q.data;
		if (WS_QUERY) begin
			case (WS_SEL)
				cmp_pkg::WS_RAW: ws_d.data = to_word(deb_state);
				cmp_pkg::WS_MASKED: ws_d.data = to_word(masked);
				cmp_pkg::WS_FIRST: ws_d.data = to_word(first_rec);
				default: ws_d.data = 16'h0000;
			endcase
		end
	end

	// or of masked channels; trigger on rise
	always_comb begin
		irq_d = |masked;
		trig_d = irq_d && !irq_q;
	end

	// all top-level state
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			cfg_q <= '{inv: cmp_pkg::INV_RST, en: cmp_pkg::EN_RST,
				deb: cmp_pkg::DEB_RST};
			la_q <= cmp_pkg::LA_RST;
			la_armed_q <= 1'b0;
			reg_q <= '0;
			ws_q <= '0;
			irq_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			la_q <= la_d;
			la_armed_q <= la_armed_d;
			reg_q <= reg_d;
			ws_q <= ws_d;
			irq_q <= irq_d;
			trig_q <= trig_d;
		end
	end

	// outputs: open collector pulls low while active
	assign INT_LEVEL = irq_q;
	assign TRIG_PULSE = trig_q;
	assign FP_IRQ_O = 1'b0;
	assign FP_IRQ_OE_B = !irq_q;
	assign FP_LATCH_O = 1'b0;
	assign FP_LATCH_OE_B = (first_rec == '0);
	assign LA_CURRENT = la_q;
	assign REG_ACK = reg_q.valid;
	assign REG_RDATA = reg_q.data;
	assign WS_VALID = ws_q.valid;
	assign WS_RDATA = ws_q.data;

	default clocking mcb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	AST_IRQ_IS_OR: assert property (
		1'b1 |=> INT_LEVEL == $past(|masked)
	) else $error("interrupt is not the or of masked channels");

	AST_MASK_BLOCKS: assert property (
		INT_LEVEL |-> $past((deb_state ^ cfg_q.inv[NCH-1:0]) &
			cfg_q.en[NCH-1:0]) != '0
	) else $error("disabled channel reached the interrupt");

	AST_MASK_NO_IRQ: assert property (
		(cfg_q.en == 16'h0000) |=> !INT_LEVEL
	) else $error("interrupt with every channel disabled");

	AST_INVERT_APPLIED: assert property (
		(reg_hit && REG_ADDR[5:0] == cmp_pkg::OFF_MASKED) |=>
			REG_RDATA == $past(to_word((deb_state ^ cfg_q.inv[NCH-1:0]) &
			cfg_q.en[NCH-1:0]))
	) else $error("masked read does not show inverted masked state");

	AST_TRIG_ON_RISE: assert property (
		TRIG_PULSE |-> INT_LEVEL ##1 !TRIG_PULSE
	) else $error("trigger pulse not tied to interrupt rise");

	AST_FP_IRQ: assert property (
		$rose(INT_LEVEL) |-> !FP_IRQ_OE_B && TRIG_PULSE
	) else $error("front panel or trigger missed the interrupt");

	AST_RAW_READ: assert property (
		(reg_hit && REG_ADDR[5:0] == cmp_pkg::OFF_RAW) |=>
			REG_ACK && REG_RDATA == $past(to_word(deb_state))
	) else $error("raw state read wrong");

	AST_FIRST_READ: assert property (
		(reg_hit && REG_ADDR[5:0] == cmp_pkg::OFF_FIRST) |=>
			REG_ACK && REG_RDATA == $past(to_word(first_rec))
	) else $error("first record read wrong");

	AST_WS_FIRST: assert property (
		(WS_QUERY && WS_SEL == cmp_pkg::WS_FIRST) |=>
			WS_VALID && WS_RDATA == $past(to_word(first_rec))
	) else $error("query did not return first record");

	AST_MISS_NO_ACK: assert property (
		(REG_RD && REG_ADDR[13:cmp_pkg::LA_LSB] != la_q) |=> !REG_ACK
	) else $error("read outside the address space answered");

	AST_LA_DYNAMIC: assert property (
		LA_SET |=> LA_CURRENT == $past(LA_NEW)
	) else $error("dynamic address not taken");

	AST_LA_STATIC: assert property (
		$rose(la_armed_q) |-> LA_CURRENT == ($past(LA_SET) ?
			$past(LA_NEW) : $past(STATIC_LA))
	) else $error("static address not taken after reset");

	AST_MASKED_READ: assert property (
		(reg_hit && REG_ADDR[5:0] == cmp_pkg::OFF_MASKED) |=>
			REG_ACK && REG_RDATA == $past(to_word(masked))
	) else $error("masked state read wrong");

	AST_OTHER_OFF_ZERO: assert property (
		(reg_hit && REG_ADDR[5:0] != cmp_pkg::OFF_RAW &&
			REG_ADDR[5:0] != cmp_pkg::OFF_MASKED &&
			REG_ADDR[5:0] != cmp_pkg::OFF_FIRST) |=>
			REG_ACK && REG_RDATA == 16'h0000
	) else $error("unused offset did not read as zero");

	AST_WS_RAW: assert property (
		(WS_QUERY && WS_SEL == cmp_pkg::WS_RAW) |=>
			WS_VALID && WS_RDATA == $past(to_word(deb_state))
	) else $error("query did not return raw states");

	AST_WS_MASKED: assert property (
		(WS_QUERY && WS_SEL == cmp_pkg::WS_MASKED) |=>
			WS_VALID && WS_RDATA == $past(to_word(masked))
	) else $error("query did not return masked states");

	COV_IRQ_RISE: cover property ($rose(INT_LEVEL));
	COV_FIRST_CLR: cover property (first_rec != '0 ##1 first_clr);
	COV_WS_RAW: cover property (WS_QUERY && WS_SEL == cmp_pkg::WS_RAW);

endmodule

// ==== verif/host_model.sv ====
// host side model: register reads and word-serial queries.
// assumes one-cycle strobes, answers one rising edge later.
module host_model (
	// clock
	input wire logic clk,
	// register reads
	output logic reg_rd,
	output logic [15:0] reg_addr,
	input wire logic reg_ack,
	input wire logic [15:0] reg_rdata,
	// queries
	output logic ws_query,
	output cmp_pkg::ws_sel_e ws_sel,
	input wire logic ws_valid,
	input wire logic [15:0] ws_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		ws_query = 1'b0;
		ws_sel = cmp_pkg::WS_NONE;
	end

	// a read of OFF_FIRST re-arms the record
	// address flipped once released so a stale value never looks valid
	task automatic reg_read(input logic [15:0] a, output logic [15:0] d,
		output logic ack);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		ack = reg_ack;
		d = reg_rdata;
	endtask

	task automatic ws_read(input cmp_pkg::ws_sel_e s, output logic [15:0] d,
		output logic v);
		@(negedge clk);
		ws_query = 1'b1;
		ws_sel = s;
		@(negedge clk);
		ws_query = 1'b0;
		ws_sel = cmp_pkg::ws_sel_e'(~s);
		v = ws_valid;
		d = ws_rdata;
	endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the comparator interrupt aggregator.
// assumes a shortened debounce step of 4 cycles and 2 steps after reset.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LA0 = 8'h05;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] lvl = 16'h0000;
	logic la_set = 1'b0;
	logic [7:0] la_new = 8'h00;
	logic cfg_wr = 1'b0;
	cmp_pkg::cfg_sel_e cfg_sel = cmp_pkg::CFG_SPARE;
	logic [15:0] cfg_data = 16'h0000;
	logic reg_rd, reg_ack, ws_query, ws_valid, ok;
	logic [15:0] reg_addr, reg_rdata, ws_rdata, d;
	cmp_pkg::ws_sel_e ws_sel;
	logic [7:0] la_cur;
	logic int_lv, trig, irq_o, irq_oe_b, lat_o, lat_oe_b;
	int n_fail = 0;
	int checked = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	comparator_interrupt_aggregator #(.STEP_CYCLES(4))
		comparator_interrupt_aggregator_i (
		.CORE_CLK(clk), .RST_B(rst_b), .CMP_LEVEL(lvl),
		.STATIC_LA(LA0), .LA_SET(la_set), .LA_NEW(la_new),
		.LA_CURRENT(la_cur), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_ACK(reg_ack), .REG_RDATA(reg_rdata), .WS_QUERY(ws_query),
		.WS_SEL(ws_sel), .WS_VALID(ws_valid), .WS_RDATA(ws_rdata),
		.CFG_WR(cfg_wr), .CFG_SEL(cfg_sel), .CFG_DATA(cfg_data),
		.INT_LEVEL(int_lv), .TRIG_PULSE(trig), .FP_IRQ_O(irq_o),
		.FP_IRQ_OE_B(irq_oe_b), .FP_LATCH_O(lat_o),
		.FP_LATCH_OE_B(lat_oe_b));

	host_model host_model_i (
		.clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .ws_query(ws_query),
		.ws_sel(ws_sel), .ws_valid(ws_valid), .ws_rdata(ws_rdata));

	task automatic final_report();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string w);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
		end
	endtask

	// register read with expected acknowledge and data
	task automatic rd(input logic [7:0] la, input logic [5:0] off,
		input logic ea, input logic [15:0] ed);
		host_model_i.reg_read({2'b11, la, off}, d, ok);
		chk({15'h0, ok}, {15'h0, ea}, "ack");
		if (ea) begin
			chk(d, ed, "rdata");
		end
	endtask

	task automatic ws(input cmp_pkg::ws_sel_e s, input logic [15:0] ed);
		host_model_i.ws_read(s, d, ok);
		chk({15'h0, ok}, 16'h0001, "ws valid");
		chk(d, ed, "ws data");
	endtask

	task automatic cfg(input cmp_pkg::cfg_sel_e s, input logic [15:0] v);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_sel = s;
		cfg_data = v;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask

	// count falling edges until the interrupt reaches a level
	task automatic wait_int(input logic l, input int n);
		int k;
		k = 0;
		while (int_lv !== l) begin
			@(negedge clk);
			k++;
			if (k > 200) begin
				n_fail++;
				$display("[ERR] %0t interrupt wait ran out", $time);
				final_report();
			end
		end
		chk(16'(k), 16'(n), "int delay");
	endtask

	task automatic t_reset();
		chk({8'h0, la_cur}, {8'h0, LA0}, "static la");
		chk({12'h0, int_lv, trig, irq_oe_b, lat_oe_b}, 16'h0003, "idle");
		chk({14'h0, irq_o, lat_o}, 16'h0000, "oc data");
		rd(LA0, cmp_pkg::OFF_RAW, 1'b1, 16'h0000);
		rd(LA0, 6'h10, 1'b1, 16'h0000);
		rd(LA0 + 8'h01, cmp_pkg::OFF_RAW, 1'b0, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_debounce();
		cfg(cmp_pkg::CFG_ENABLE, 16'hffff);
		lvl = 16'h0001;
		repeat (5) @(negedge clk);
		lvl = 16'h0000;
		@(negedge clk);
		lvl = 16'h0001;
		wait_int(1'b1, 9);
		chk({14'h0, trig, irq_oe_b}, 16'h0002, "trig");
		@(negedge clk);
		chk({15'h0, trig}, 16'h0000, "trig end");
		rd(LA0, cmp_pkg::OFF_RAW, 1'b1, 16'h0001);
		rd(LA0, cmp_pkg::OFF_MASKED, 1'b1, 16'h0001);
		$display("test debounce done");
	endtask

	task automatic t_first();
		lvl = 16'h0005;
		repeat (10) @(negedge clk);
		chk({15'h0, lat_oe_b}, 16'h0000, "latch pin");
		rd(LA0, cmp_pkg::OFF_FIRST, 1'b1, 16'h0001);
		rd(LA0, cmp_pkg::OFF_FIRST, 1'b1, 16'h0000);
		chk({15'h0, lat_oe_b}, 16'h0001, "latch free");
		cfg(cmp_pkg::CFG_INVERT, 16'h0008);
		rd(LA0, cmp_pkg::OFF_MASKED, 1'b1, 16'h000d);
		ws(cmp_pkg::WS_FIRST, 16'h0008);
		ws(cmp_pkg::WS_FIRST, 16'h0000);
		$display("test first done");
	endtask

	task automatic t_mask();
		cfg(cmp_pkg::CFG_ENABLE, 16'h0000);
		wait_int(1'b0, 1);
		chk({15'h0, irq_oe_b}, 16'h0001, "irq pin");
		ws(cmp_pkg::WS_RAW, 16'h0005);
		ws(cmp_pkg::WS_MASKED, 16'h0000);
		ws(cmp_pkg::WS_NONE, 16'h0000);
		$display("test mask done");
	endtask

	task automatic t_la();
		@(negedge clk);
		la_set = 1'b1;
		la_new = 8'h2a;
		@(negedge clk);
		la_set = 1'b0;
		chk({8'h0, la_cur}, 16'h002a, "dyn la");
		rd(LA0, cmp_pkg::OFF_RAW, 1'b0, 16'h0000);
		rd(8'h2a, cmp_pkg::OFF_RAW, 1'b1, 16'h0005);
		$display("test address done");
	endtask

	// programmed step count, clamp to the minimum, ignored selector
	task automatic t_steps();
		cfg(cmp_pkg::CFG_DEBOUNCE, 16'h0003);
		cfg(cmp_pkg::CFG_ENABLE, 16'h0002);
		cfg(cmp_pkg::CFG_SPARE, 16'hffff);
		lvl = 16'h0007;
		wait_int(1'b1, 13);
		cfg(cmp_pkg::CFG_DEBOUNCE, 16'h0001);
		lvl = 16'h0005;
		wait_int(1'b0, 9);
		ws(cmp_pkg::WS_FIRST, 16'h0002);
		$display("test steps done");
	endtask

	// reset again in mid-run, held two edges
	task automatic t_rst_mid();
		@(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		chk({8'h0, la_cur}, {8'h0, LA0}, "la again");
		chk({12'h0, int_lv, trig, irq_oe_b, lat_oe_b}, 16'h0003, "idle2");
		rd(8'h2a, cmp_pkg::OFF_RAW, 1'b0, 16'h0000);
		rd(LA0, cmp_pkg::OFF_FIRST, 1'b1, 16'h0000);
		$display("test reset again done");
	endtask

	// main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_debounce();
		t_first();
		t_mask();
		t_steps();
		t_la();
		t_rst_mid();
		final_report();
	end
endmodule
